// ### rtl/mlf_top.sv
// Top of the motor lock fault response block with its Wishbone register slave.
// Overview of operation
// - A current-limit lock must persist for the filter time chosen by a 4-bit code (1 ms to 50 s).
// - After a per-cycle current clamp, drive is held off for 0 to 7 PWM cycles before retrying.
// - Stall modes 0h-3h latch a fault, assert fault_indicator_n and apply the coded gate state.
// - Stall modes 4h-7h apply the coded gate state and recover after the stall retry wait.
// - Within each group of four codes the gate states are tristate, recirculation, HS, LS brake.
// - Stall mode 8h only reports the stall, with no change to the gate drive.
// - Stall modes 9h-Fh disable stall detection completely.
// - The stall retry wait is 100, 500, 1000, 2000, 3000, 5000, 7500 or 10000 ms by a 3-bit code.
// - A filtered current-limit lock uses its own 4-bit mode field with the same code groups.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module mlf_top #(
    parameter int MS_TICK_CYCLES = mlf_pkg::MS_CYCLES
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Wishbone slave.
    input  wire mlf_pkg::mlf_wb_req_s  wb_req,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // Lock detectors and PWM timing, all on clk.
    input  wire logic                  stall_detect,
    input  wire logic                  clamp_lock_level,
    input  wire logic                  per_cycle_clamp,
    input  wire logic                  pwm_cycle_start,
    // Gate-drive stage and indicators.
    output mlf_pkg::mlf_gate_s         gate_ctl,
    output logic                       clamp_retry_hold,
    output logic                       fault_indicator_n,
    output logic                       irq
);
    import mlf_pkg::*;

    initial begin
        if (MS_TICK_CYCLES < 1) $error("MS_TICK_CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.
    logic [31:0]     setup_one_ff;
    logic [31:0]     setup_two_ff;
    logic [ST_W-1:0] status_ff;
    logic [ST_W-1:0] enable_ff;
    logic            fault_clear_ff;
    logic            ack_ff;
    logic [31:0]     dat_ff;
    logic            irq_ff;

    // Drive-side flip-flops, declared here because the state word reads them.
    mlf_gate_s              gate_ff;
    logic                   fault_n_ff;
    logic                   clamp_retry_hold_ff;

    // Field extraction from fault_setup_one.
    wire [MODE_W-1:0]      stall_response_select   = setup_one_ff[FLD_STALL_MODE_LSB +: MODE_W];
    wire [MODE_W-1:0]      clamp_response_select   = setup_one_ff[FLD_CLAMP_MODE_LSB +: MODE_W];
    wire [FILTER_W-1:0]    current_clamp_lock_filter_time = setup_one_ff[FLD_FILTER_LSB +: FILTER_W];
    wire [RETRY_CYC_W-1:0] clamp_retry_cycle_count = setup_one_ff[FLD_RETRY_CYC_LSB +: RETRY_CYC_W];
    wire [INTERVAL_W-1:0]  stall_retry_interval_select = setup_one_ff[FLD_INTERVAL_LSB +: INTERVAL_W];
    wire [MS_W-1:0]        stall_retry_wait        = INTERVAL_MS[stall_retry_interval_select];
    wire [MS_W-1:0]        filter_ms               = FILTER_MS[current_clamp_lock_filter_time];

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone decode: one aligned word per register, byte lanes by sel.
    wire        wb_hit     = wb_req.cyc && wb_req.stb && !ack_ff;
    wire        wb_wr      = wb_hit && wb_req.we;
    wire [31:0] lane_mask  = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                              {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
    wire        wr_one     = wb_wr && (wb_req.adr == ADDR_SETUP_ONE);
    wire        wr_two     = wb_wr && (wb_req.adr == ADDR_SETUP_TWO);
    wire        wr_clear   = wb_wr && (wb_req.adr == ADDR_CLEAR) && wb_req.sel[0];
    wire        wr_enable  = wb_wr && (wb_req.adr == ADDR_ENABLE) && wb_req.sel[0];
    wire        wr_control = wb_wr && (wb_req.adr == ADDR_CONTROL) && wb_req.sel[0];
    wire [31:0] one_wmask  = lane_mask & SETUP_ONE_MASK;
    wire [31:0] nxt_one    = (setup_one_ff & ~one_wmask) | (wb_req.dat & one_wmask);
    wire [31:0] nxt_two    = (setup_two_ff & ~lane_mask) | (wb_req.dat & lane_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped and write-only addresses read as zero.
    wire mlf_chan_s chan_info [2];
    wire mlf_gate_s chan_gate [2];
    wire [31:0] state_word = {22'h00_0000, clamp_retry_hold_ff, !fault_n_ff,
                              chan_info[1].retrying, chan_info[1].latched,
                              chan_info[0].retrying, chan_info[0].latched,
                              gate_ff.hold, gate_ff.state, 1'b0};
    wire [31:0] nxt_dat =
        (wb_req.adr == ADDR_SETUP_ONE) ? setup_one_ff :
        (wb_req.adr == ADDR_SETUP_TWO) ? setup_two_ff :
        (wb_req.adr == ADDR_STATUS)    ? {27'h000_0000, status_ff} :
        (wb_req.adr == ADDR_ENABLE)    ? {27'h000_0000, enable_ff} :
        (wb_req.adr == ADDR_STATE)     ? state_word : 32'h0000_0000;

    // Bus handshake: answer one cycle after the request, drop the next cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= wb_hit;
            dat_ff <= wb_hit ? nxt_dat : 32'h0000_0000;
        end
    end

    // Configuration registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            setup_one_ff   <= SETUP_ONE_RST;
            setup_two_ff   <= SETUP_TWO_RST;
            enable_ff      <= '0;
            fault_clear_ff <= 1'b0;
        end else begin
            if (wr_one) setup_one_ff <= nxt_one;
            if (wr_two) setup_two_ff <= nxt_two;
            if (wr_enable) enable_ff <= wb_req.dat[ST_W-1:0];
            fault_clear_ff <= wr_control && wb_req.dat[CTRL_FAULT_CLEAR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Current-limit lock filter: the level must persist for the selected time.
    logic [31:0]     dg_pre_ff;
    logic [MS_W-1:0] dg_ms_ff;
    logic            dg_done_ff;
    wire dg_run     = clamp_lock_level && (clamp_response_select < MODE_DISABLED_MIN);
    wire dg_tick    = (dg_pre_ff == 32'(MS_TICK_CYCLES - 1));
    wire clamp_evt  = dg_run && !dg_done_ff && dg_tick && (dg_ms_ff == filter_ms - 16'h0001);

    // The filter restarts whenever the level drops, so only an unbroken level counts.
    always_ff @(posedge clk) begin
        if (rst) begin
            dg_pre_ff  <= 32'h0000_0000;
            dg_ms_ff   <= '0;
            dg_done_ff <= 1'b0;
        end else begin
            dg_pre_ff  <= (!dg_run || dg_done_ff || dg_tick) ? 32'h0000_0000 : dg_pre_ff + 32'h0000_0001;
            dg_ms_ff   <= !dg_run ? '0 : (dg_tick ? dg_ms_ff + 16'h0001 : dg_ms_ff);
            dg_done_ff <= dg_run && (dg_done_ff || clamp_evt);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Response channels: index 0 handles stalls, index 1 the filtered clamp lock.
    wire             chan_evt  [2];
    wire [MODE_W-1:0] chan_mode [2];
    assign chan_evt[0]  = stall_detect;
    assign chan_evt[1]  = clamp_evt;
    assign chan_mode[0] = stall_response_select;
    assign chan_mode[1] = clamp_response_select;

    for (genvar i = 0; i < 2; i++) begin : g_chan
        mlf_lock_chan #(
            .MS_TICK_CYCLES (MS_TICK_CYCLES)
        ) u_chan (
            .clk         (clk),
            .rst         (rst),
            .lock_evt    (chan_evt[i]),
            .mode        (chan_mode[i]),
            .interval_ms (stall_retry_wait),
            .fault_clear (fault_clear_ff),
            .gate        (chan_gate[i]),
            .info        (chan_info[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Gate-drive selection: the stall response wins over the clamp response.
    wire mlf_gate_s nxt_gate = chan_gate[0].hold ? chan_gate[0] :
                               chan_gate[1].hold ? chan_gate[1] : '0;
    wire nxt_fault_n = !(chan_info[0].latched || chan_info[1].latched);

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_ff    <= '0;
            fault_n_ff <= 1'b1;
        end else begin
            gate_ff    <= nxt_gate;
            fault_n_ff <= nxt_fault_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-cycle clamp retry: hold off drive for the selected number of PWM cycles.
    logic [RETRY_CYC_W-1:0] pwm_cnt_ff;
    wire retry_done = clamp_retry_hold_ff && (pwm_cnt_ff == clamp_retry_cycle_count);

    always_ff @(posedge clk) begin
        if (rst) begin
            clamp_retry_hold_ff <= 1'b0;
            pwm_cnt_ff          <= '0;
        end else if (per_cycle_clamp) begin
            clamp_retry_hold_ff <= 1'b1;
            pwm_cnt_ff          <= '0;
        end else if (retry_done) begin
            clamp_retry_hold_ff <= 1'b0;
        end else if (clamp_retry_hold_ff && pwm_cycle_start) begin
            pwm_cnt_ff          <= pwm_cnt_ff + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky status: a new event wins over a clear in the same cycle.
    wire [ST_W-1:0] evt_vec   = {retry_done, chan_info[1].recovered, chan_info[0].recovered,
                                 chan_info[1].report, chan_info[0].report};
    wire [ST_W-1:0] clr_vec   = wr_clear ? wb_req.dat[ST_W-1:0] : '0;
    wire [ST_W-1:0] nxt_stat  = (status_ff & ~clr_vec) | evt_vec;

    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= '0;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_stat;
            irq_ff    <= |(nxt_stat & enable_ff);
        end
    end

    // Outputs straight from flip-flops.
    assign wb_dat_o          = dat_ff;
    assign wb_ack_o          = ack_ff;
    assign gate_ctl          = gate_ff;
    assign clamp_retry_hold  = clamp_retry_hold_ff;
    assign fault_indicator_n = fault_n_ff;
    assign irq               = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the block's own behaviour.
    AST_ACK_PULSE: assert property (@(posedge clk) disable iff (rst)
        wb_hit |=> ack_ff ##1 !ack_ff)
        else $error("Bus answer not a single cycle");
    AST_FILTER_TIME: assert property (@(posedge clk) disable iff (rst)
        clamp_evt |-> clamp_lock_level && (dg_ms_ff == filter_ms - 16'h0001) && dg_tick)
        else $error("Clamp lock reported before its filter time");
    AST_RETRY_COUNT: assert property (@(posedge clk) disable iff (rst)
        (clamp_retry_hold_ff && !per_cycle_clamp && pwm_cnt_ff == clamp_retry_cycle_count)
        |=> !clamp_retry_hold_ff)
        else $error("Clamp retry held past its cycle count");
    AST_STALL_LATCH: assert property (@(posedge clk) disable iff (rst)
        (stall_detect && stall_response_select < MODE_AUTO_BASE && !chan_gate[0].hold)
        |=> ##1 !fault_indicator_n && gate_ctl.hold
            && gate_ctl.state == mlf_gate_e'($past(stall_response_select[1:0], 2)))
        else $error("Latched stall did not assert fault indicator and gate state");
    AST_STALL_AUTO: assert property (@(posedge clk) disable iff (rst)
        (stall_detect && !chan_gate[0].hold && stall_response_select >= MODE_AUTO_BASE
         && stall_response_select < MODE_REPORT) |=> chan_info[0].retrying && !chan_info[0].latched)
        else $error("Auto-recovery stall mode did not start its retry wait");
    AST_REPORT_ONLY: assert property (@(posedge clk) disable iff (rst)
        (stall_detect && !chan_gate[0].hold && stall_response_select == MODE_REPORT)
        |=> !chan_gate[0].hold ##1 status_ff[ST_STALL_LOCK])
        else $error("Report-only stall changed the drive or was not reported");
    AST_CLAMP_MODE: assert property (@(posedge clk) disable iff (rst)
        (clamp_evt && !chan_gate[1].hold && clamp_response_select < MODE_AUTO_BASE)
        |=> chan_info[1].latched)
        else $error("Clamp lock did not follow its own mode field");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
        (chan_info[0].latched && !fault_clear_ff) |=> chan_info[0].latched ##1 !fault_indicator_n)
        else $error("Latched fault released without a clear");
    AST_STICKY: assert property (@(posedge clk) disable iff (rst)
        (evt_vec[ST_STALL_LOCK]) |=> status_ff[ST_STALL_LOCK])
        else $error("Status event lost against a clear");

    COV_LATCH_CLEAR: cover property (@(posedge clk) disable iff (rst)
        chan_info[0].latched ##1 fault_clear_ff ##1 !chan_info[0].latched);
    COV_AUTO_RECOVER: cover property (@(posedge clk) disable iff (rst) chan_info[0].recovered);
    COV_CLAMP_LOCK: cover property (@(posedge clk) disable iff (rst) clamp_evt);
    COV_RETRY_DONE: cover property (@(posedge clk) disable iff (rst) retry_done && irq_ff);

endmodule // mlf_top
`default_nettype wire

// ### rtl/mlf_pkg.sv
// Package of constants, types and lookup tables for the motor lock fault response block.
package mlf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: one millisecond expressed in clock cycles of the 8 ns clock.
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the Wishbone slave.
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADDR_SETUP_ONE = 8'h90;
    localparam logic [ADR_W-1:0] ADDR_SETUP_TWO = 8'h94;
    localparam logic [ADR_W-1:0] ADDR_STATUS    = 8'h98;
    localparam logic [ADR_W-1:0] ADDR_CLEAR     = 8'h9C;
    localparam logic [ADR_W-1:0] ADDR_ENABLE    = 8'hA0;
    localparam logic [ADR_W-1:0] ADDR_CONTROL   = 8'hA4;
    localparam logic [ADR_W-1:0] ADDR_STATE     = 8'hA8;

    // Reset values and writable bits.
    localparam logic [31:0] SETUP_ONE_RST  = 32'h0000_0000;
    localparam logic [31:0] SETUP_ONE_MASK = 32'h0007_FFFF;
    localparam logic [31:0] SETUP_TWO_RST  = 32'h0000_0000;

    // Field positions inside fault_setup_one.
    localparam int FLD_CLAMP_MODE_LSB = 15;
    localparam int FLD_FILTER_LSB     = 11;
    localparam int FLD_RETRY_CYC_LSB  = 8;
    localparam int FLD_STALL_MODE_LSB = 3;
    localparam int FLD_INTERVAL_LSB   = 0;
    localparam int MODE_W             = 4;
    localparam int FILTER_W           = 4;
    localparam int RETRY_CYC_W        = 3;
    localparam int INTERVAL_W         = 3;

    // Response mode code groups shared by both lock sources.
    localparam logic [3:0] MODE_AUTO_BASE    = 4'h4;
    localparam logic [3:0] MODE_REPORT       = 4'h8;
    localparam logic [3:0] MODE_DISABLED_MIN = 4'h9;

    // Status, clear and enable bit positions.
    localparam int ST_STALL_LOCK  = 0;
    localparam int ST_CLAMP_LOCK  = 1;
    localparam int ST_STALL_RECOV = 2;
    localparam int ST_CLAMP_RECOV = 3;
    localparam int ST_CLAMP_RETRY = 4;
    localparam int ST_W           = 5;

    // Control register: write one to release latched faults.
    localparam int CTRL_FAULT_CLEAR = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond tables for the filter time and the retry interval.
    localparam int MS_W = 16;
    localparam logic [MS_W-1:0] FILTER_MS [16] = '{
        16'h0001, 16'h0002, 16'h0005, 16'h000A, 16'h0019, 16'h0032, 16'h004B, 16'h0064,
        16'h00FA, 16'h01F4, 16'h03E8, 16'h09C4, 16'h1388, 16'h2710, 16'h61A8, 16'hC350};
    localparam logic [MS_W-1:0] INTERVAL_MS [8] = '{
        16'h0064, 16'h01F4, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h1388, 16'h1D4C, 16'h2710};

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [1:0] {
        MLF_GATE_TRISTATE,
        MLF_GATE_RECIRC,
        MLF_GATE_HS_BRAKE,
        MLF_GATE_LS_BRAKE
    } mlf_gate_e;

    typedef struct packed {
        logic      hold;
        mlf_gate_e state;
    } mlf_gate_s;

    typedef struct packed {
        logic latched;
        logic retrying;
        logic report;
        logic recovered;
    } mlf_chan_s;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [3:0]       sel;
        logic [ADR_W-1:0] adr;
        logic [31:0]      dat;
    } mlf_wb_req_s;

endpackage

// ### rtl/mlf_lock_chan.sv
// Response state machine for one lock source: latched, auto-retry, report or off.
`timescale 1ns/1ns
`default_nettype none
module mlf_lock_chan #(
    parameter int MS_TICK_CYCLES = mlf_pkg::MS_CYCLES
) (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Detection and configuration.
    input  wire logic                     lock_evt,
    input  wire logic [mlf_pkg::MODE_W-1:0] mode,
    input  wire logic [mlf_pkg::MS_W-1:0] interval_ms,
    input  wire logic                     fault_clear,
    // Response.
    output mlf_pkg::mlf_gate_s            gate,
    output mlf_pkg::mlf_chan_s            info
);
    import mlf_pkg::*;

    typedef enum logic [1:0] {LC_IDLE, LC_LATCHED, LC_WAIT} mlf_lc_e;

    mlf_lc_e      st_ff;
    mlf_lc_e      nxt_st;
    logic [31:0]  pre_ff;
    logic [MS_W-1:0] ms_ff;
    mlf_gate_e    code_ff;
    logic         report_ff;
    logic         recov_ff;

    initial begin
        if (MS_TICK_CYCLES < 1) $error("MS_TICK_CYCLES must be at least one");
    end

    // Decode of the incoming event against the selected mode.
    wire take      = lock_evt && (st_ff == LC_IDLE) && (mode < MODE_DISABLED_MIN);
    wire go_latch  = take && (mode < MODE_AUTO_BASE);
    wire go_wait   = take && (mode >= MODE_AUTO_BASE) && (mode < MODE_REPORT);
    wire ms_tick   = (pre_ff == 32'(MS_TICK_CYCLES - 1));
    wire elapsed   = (st_ff == LC_WAIT) && ms_tick && (ms_ff == interval_ms - 16'h0001);

    // Next state selection.
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            LC_IDLE: begin
                if (go_latch) nxt_st = LC_LATCHED;
                else if (go_wait) nxt_st = LC_WAIT;
            end
            LC_LATCHED: begin
                if (fault_clear) nxt_st = LC_IDLE;
            end
            LC_WAIT: begin
                if (elapsed) nxt_st = LC_IDLE;
            end
            default: nxt_st = LC_IDLE;
        endcase
    end

    // State, interval timer and captured gate-drive code.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff     <= LC_IDLE;
            pre_ff    <= 32'h0000_0000;
            ms_ff     <= '0;
            code_ff   <= MLF_GATE_TRISTATE;
            report_ff <= 1'b0;
            recov_ff  <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            pre_ff    <= (st_ff != LC_WAIT || ms_tick) ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
            ms_ff     <= (st_ff != LC_WAIT) ? '0 : (ms_tick ? ms_ff + 16'h0001 : ms_ff);
            report_ff <= take;
            recov_ff  <= elapsed;
            if (go_latch || go_wait) code_ff <= mlf_gate_e'(mode[1:0]);
        end
    end

    assign gate.hold      = (st_ff != LC_IDLE);
    assign gate.state     = code_ff;
    assign info.latched   = (st_ff == LC_LATCHED);
    assign info.retrying  = (st_ff == LC_WAIT);
    assign info.report    = report_ff;
    assign info.recovered = recov_ff;

    // Waiting never reaches the full interval count and never reports a latched fault.
    AST_WAIT_BOUND: assert property (@(posedge clk) disable iff (rst)
        (st_ff == LC_WAIT) |-> (ms_ff < interval_ms) && !info.latched)
        else $error("Retry wait ran past its interval");
    AST_DISABLED: assert property (@(posedge clk) disable iff (rst)
        (st_ff == LC_IDLE && mode >= MODE_DISABLED_MIN) |=> (st_ff == LC_IDLE) && !report_ff)
        else $error("Disabled detection still acted");

endmodule // mlf_lock_chan
`default_nettype wire

// ### verif/mlf_drive_model.sv
// Drive stage model: makes the PWM cycle start pulse.
`timescale 1ns/1ns
`default_nettype none
module mlf_drive_model #(
    parameter int PWM_DIV = 16
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // PWM timing.
    output logic      pwm_cycle_start
);
    int cnt_ff;
    // Counts one PWM period and pulses at its start.
    always_ff @(posedge clk) begin
        cnt_ff <= (rst || cnt_ff == PWM_DIV - 1) ? 0 : cnt_ff + 1;
        pwm_cycle_start <= !rst && cnt_ff == PWM_DIV - 1;
    end
endmodule // mlf_drive_model
`default_nettype wire

// ### verif/mlf_top_bench.sv
// Self-checking bench of the lock fault response block.
`timescale 1ns/1ns
`default_nettype none
module mlf_top_bench;
    import mlf_pkg::*;
    logic        clk = 0, rst = 1, stall = 0, lvl = 0, pcc = 0;
    logic        pwm, ack, flt_n, hold, irq;
    logic [31:0] rd, dat;
    mlf_wb_req_s req = '0;
    mlf_gate_s   gate;
    int          err_total = 0, check_count = 0, cyc_n = 0, n;
    always #4 clk = ~clk;
    mlf_top #(.MS_TICK_CYCLES(4)) mlf_top_i (.clk(clk), .rst(rst), .wb_req(req),
        .wb_dat_o(dat), .wb_ack_o(ack), .stall_detect(stall), .clamp_lock_level(lvl),
        .per_cycle_clamp(pcc), .pwm_cycle_start(pwm), .gate_ctl(gate),
        .clamp_retry_hold(hold), .fault_indicator_n(flt_n), .irq(irq));
    mlf_drive_model mlf_drive_model_i (.clk(clk), .rst(rst), .pwm_cycle_start(pwm));
    ////////////////////////////////////////////////////////////////////////////////
    // Model of the gate state: latched and auto codes drive, others leave it off.
    function automatic logic [31:0] exp_gate(input int m);
        return (m < 8) ? {29'h0, 1'h1, m[1:0]} : 32'h0;
    endfunction
    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic bus cycle; holds the request until ack is sampled.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk) req <= '{1'h1, 1'h1, we, 4'hF, adr, wd};
        do @(posedge clk); while (ack !== 1'h1);
        rd = dat;
        req <= '0;
    endtask
    // Waits k edges, then moves to a settled point.
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(80285));
        repeat (8) @(posedge clk);
        rst <= 0;
        wb(0, ADDR_SETUP_ONE, 0);
        chk(rd, SETUP_ONE_RST);
        n = $urandom;
        wb(1, ADDR_SETUP_TWO, n);
        wb(0, ADDR_SETUP_TWO, 0);
        chk(rd, n);
        wb(0, 8'h00, 0);
        chk(rd, 0);
        wb(1, ADDR_ENABLE, 1);
        // Every stall code; the clamp source stays disabled.
        for (int m = 0; m < 16; m++) begin
            wb(1, ADDR_CLEAR, 32'h1F);
            wb(1, ADDR_SETUP_ONE, (m << 3) | 32'h48000);
            @(posedge clk) stall <= 1;
            @(posedge clk) stall <= 0;
            settle(4);
            chk(32'(gate), exp_gate(m));
            chk(32'(flt_n), 32'(m > 3));
            chk(32'(irq), 32'(m < 9));
            if (m == 8) begin
                wb(1, ADDR_ENABLE, 0);
                settle(2);
                chk(32'(irq), 0);
                wb(1, ADDR_ENABLE, 1);
            end
            settle(420);
            chk(32'(gate), m < 4 ? exp_gate(m) : 0);
            wb(1, ADDR_CONTROL, 1);
            settle(4);
            chk(32'(flt_n), 1);
        end
        // Clamp lock: a short level is filtered out, a long one latches.
        wb(1, ADDR_SETUP_ONE, 32'h18348);
        @(posedge clk) lvl <= 1;
        repeat (2) @(posedge clk);
        lvl <= 0;
        settle(8);
        chk(32'(gate), 0);
        @(posedge clk) lvl <= 1;
        settle(9);
        chk(32'(gate), exp_gate(3));
        // Per-cycle clamp holds drive off for three PWM cycles.
        @(posedge clk) pcc <= 1;
        @(posedge clk) pcc <= 0;
        settle(1);
        chk(32'(hold), 1);
        n = 0;
        while (hold === 1'h1) begin
            n += pwm;
            @(negedge clk);
        end
        chk(n, 3);
        give_verdict();
    end
endmodule // mlf_top_bench
`default_nettype wire
